// [loader_pkg.sv]
// constants and types shared by the configuration-memory loader
`default_nettype none
package loader_pkg;
	localparam int WORD_W = 16;
	localparam int BYTE_W = 8;
	localparam int CONT_BIT = 15;
	localparam int SIG_MSB = 15;
	localparam int SIG_LSB = 4;
	localparam logic [11:0] HDR_SIG = 12'h840;
	localparam int ZF_LOCAL = 3;
	localparam int ZF_IDENT = 2;
	localparam int ZF_PCI = 1;
	localparam int ZF_FACC = 0;
	localparam int FN_MSB = 2;
	localparam int FN_LSB = 0;
	localparam logic [2:0] FN_FIRST = 3'h0;
	localparam int OFS_MSB = 14;
	localparam int OFS_LSB = 8;
	localparam int DAT_MSB = 7;
	localparam int DAT_LSB = 0;
	localparam int WIN_MSB = 14;
	localparam int WIN_LSB = 12;
	localparam int RW_BIT = 11;
	localparam logic [2:0] WIN_ZERO = 3'h0;
	localparam logic [2:0] WIN_ONE = 3'h1;
	localparam int CFG_OFS_W = 7;
	localparam int NUM_CFG = 11;
	localparam logic [CFG_OFS_W-1:0] CFG_OFS [NUM_CFG] = '{7'h02, 7'h03, 7'h06, 7'h09, 7'h0A, 7'h0B,
		7'h2E, 7'h2F, 7'h3D, 7'h42, 7'h43};
	localparam logic [BYTE_W-1:0] CFG_MASK [NUM_CFG] = '{8'hFF, 8'hFF, 8'h10, 8'hFF, 8'hFF, 8'hFF,
		8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'hFF};
	localparam logic [CFG_OFS_W-1:0] OFS_VENDOR = 7'h00;
	localparam logic [CFG_OFS_W-1:0] OFS_SUBVENDOR = 7'h2C;
	localparam int IDX_DEV = 0;
	localparam int IDX_STAT = 2;
	localparam int IDX_CLASS = 3;
	localparam int IDX_SUBSYS = 6;
	localparam int IDX_INTPIN = 8;
	localparam int IDX_PM = 9;
	localparam int APB_AW = 8;
	localparam logic [APB_AW-1:0] REG_CTRL = 8'h00;
	localparam logic [APB_AW-1:0] REG_STATUS = 8'h04;
	localparam logic [APB_AW-1:0] REG_IDS = 8'h08;
	localparam logic [APB_AW-1:0] REG_CLASS = 8'h0C;
	localparam logic [APB_AW-1:0] REG_PM = 8'h10;
	localparam int CTRL_RELOAD = 0;
	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_HDR = 4'h1,
		ST_SKIP = 4'h2,
		ST_FHDR = 4'h3,
		ST_CFG = 4'h4,
		ST_FA1 = 4'h5,
		ST_FA2 = 4'h6,
		ST_FACC = 4'h7
	} load_state_t;
endpackage
`default_nettype wire

// [cfg_wr_if.sv]
// byte write path from the loader into the config override store
`default_nettype none
interface cfg_wr_if;
	logic valid;
	logic [loader_pkg::CFG_OFS_W-1:0] offset;
	logic [loader_pkg::BYTE_W-1:0] data;
	logic [loader_pkg::NUM_CFG*loader_pkg::BYTE_W-1:0] image;
	modport loader (output valid, output offset, output data, input image);
	modport store (input valid, input offset, input data, output image);
endinterface
`default_nettype wire

// [cfg_override_store.sv]
// loadable PCI configuration bytes of the first function
`default_nettype none
module cfg_override_store #(
	// default values of all eleven loadable bytes; values are arbitrary
	parameter logic [loader_pkg::NUM_CFG*loader_pkg::BYTE_W-1:0] RESET_IMAGE = 88'h00_01_01_00_00_00_00_00_00_00_01
) (
	input wire logic ref_clk,
	input wire logic reset,
	cfg_wr_if.store wr
);
	logic [loader_pkg::NUM_CFG*loader_pkg::BYTE_W-1:0] image;
	logic [loader_pkg::NUM_CFG*loader_pkg::BYTE_W-1:0] next_image;

	// offsets outside the table, vendor ids included, match no entry
	for (genvar i = 0; i < loader_pkg::NUM_CFG; i++) begin : g_byte
		always_comb begin
			next_image[i*loader_pkg::BYTE_W +: loader_pkg::BYTE_W] = image[i*loader_pkg::BYTE_W +: loader_pkg::BYTE_W];
			if (wr.valid && wr.offset == loader_pkg::CFG_OFS[i]) begin
				next_image[i*loader_pkg::BYTE_W +: loader_pkg::BYTE_W] = wr.data & loader_pkg::CFG_MASK[i];
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			image <= RESET_IMAGE;
		end else begin
			image <= next_image;
		end
	end

	assign wr.image = image;

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	dev_id_load_a: assert property (wr.valid && wr.offset == 7'h02 |=> image[7:0] == $past(wr.data))
		else $error("device id low byte not loaded");
	pm_cap_load_a: assert property (wr.valid && wr.offset == 7'h43 |=> image[87:80] == $past(wr.data))
		else $error("pm capability high byte not loaded");
	int_pin_load_a: assert property (wr.valid && wr.offset == 7'h3D |=> image[71:64] == $past(wr.data))
		else $error("interrupt pin byte not loaded");
	status_mask_a: assert property (wr.valid && wr.offset == 7'h06 |=> image[23:16] == ($past(wr.data) & 8'h10))
		else $error("status byte loaded outside the capability flag");
	vendor_ignored_a: assert property (wr.valid && (wr.offset == loader_pkg::OFS_VENDOR ||
		wr.offset == loader_pkg::OFS_SUBVENDOR) |=> $stable(image))
		else $error("vendor id write changed the image");
endmodule // cfg_override_store
`default_nettype wire

// [cfg_loader.sv]
// configuration-memory loader: pci override zone and function access zone
//
// The implementer's own choices: the register offsets and the APB register port.
`default_nettype none
module cfg_loader #(
	parameter int EE_AW = 8
) (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [loader_pkg::APB_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic word_req,
	output logic [EE_AW-1:0] word_addr,
	input wire logic word_ack,
	input wire logic [loader_pkg::WORD_W-1:0] word_data,
	output logic fa_req,
	output logic fa_window,
	output logic fa_write,
	output logic [loader_pkg::BYTE_W-1:0] fa_offset,
	output logic [loader_pkg::BYTE_W-1:0] fa_wdata,
	input wire logic fa_ack,
	input wire logic [loader_pkg::BYTE_W-1:0] fa_rdata,
	output logic pci_retry,
	output logic [loader_pkg::NUM_CFG*loader_pkg::BYTE_W-1:0] cfg_image
);
	cfg_wr_if wr ();

	cfg_override_store u_store (
		.ref_clk(ref_clk),
		.reset(reset),
		.wr(wr)
	);

	loader_pkg::load_state_t state, next_state;
	logic next_word_req;
	logic [EE_AW-1:0] next_word_addr;
	logic [3:0] pending, next_pending;
	logic func_ok, next_func_ok;
	logic [loader_pkg::WORD_W-1:0] first_word, next_first_word;
	logic fa_more, next_fa_more;
	logic next_fa_req, next_fa_window, next_fa_write;
	logic [loader_pkg::BYTE_W-1:0] next_fa_offset, next_fa_wdata;
	logic wr_valid, next_wr_valid;
	logic [loader_pkg::CFG_OFS_W-1:0] wr_offset, next_wr_offset;
	logic [loader_pkg::BYTE_W-1:0] wr_data, next_wr_data;
	logic next_pci_retry;
	logic hdr_ok, next_hdr_ok;
	logic rsvd_seen, next_rsvd_seen;
	logic loaded, next_loaded;
	logic reload_req, next_reload_req;
	logic [31:0] next_prdata;
	logic next_pready, next_pslverr;
	logic got;
	logic cont;
	logic [2:0] win_code;

	assign wr.valid = wr_valid;
	assign wr.offset = wr_offset;
	assign wr.data = wr_data;
	assign cfg_image = wr.image;
	assign got = word_req && word_ack;
	assign cont = word_data[loader_pkg::CONT_BIT];
	assign win_code = first_word[loader_pkg::WIN_MSB:loader_pkg::WIN_LSB];

	// next zone in header order among those still pending
	function automatic loader_pkg::load_state_t route(input logic [3:0] p);
		if (p[loader_pkg::ZF_LOCAL] || p[loader_pkg::ZF_IDENT]) begin
			return loader_pkg::ST_SKIP;
		end else if (p[loader_pkg::ZF_PCI]) begin
			return loader_pkg::ST_FHDR;
		end else if (p[loader_pkg::ZF_FACC]) begin
			return loader_pkg::ST_FA1;
		end
		return loader_pkg::ST_IDLE;
	endfunction

	always_comb begin
		next_state = state;
		next_word_req = word_req;
		next_word_addr = word_addr;
		next_pending = pending;
		next_func_ok = func_ok;
		next_first_word = first_word;
		next_fa_more = fa_more;
		next_fa_req = fa_req;
		next_fa_window = fa_window;
		next_fa_write = fa_write;
		next_fa_offset = fa_offset;
		next_fa_wdata = fa_wdata;
		next_wr_valid = 1'b0;
		next_wr_offset = wr_offset;
		next_wr_data = wr_data;
		next_pci_retry = pci_retry;
		next_hdr_ok = hdr_ok;
		next_rsvd_seen = rsvd_seen;
		next_loaded = loaded;
		if (state != loader_pkg::ST_IDLE && state != loader_pkg::ST_FACC) begin
			next_word_req = ~got;
		end
		if (got) begin
			next_word_addr = word_addr + 1'b1;
		end
		unique case (state)
			loader_pkg::ST_IDLE: begin
				next_word_req = 1'b0;
				if (reload_req) begin
					next_state = loader_pkg::ST_HDR;
					next_word_addr = '0;
					next_pci_retry = 1'b1;
					next_hdr_ok = 1'b0;
					next_rsvd_seen = 1'b0;
					next_loaded = 1'b0;
				end
			end
			loader_pkg::ST_HDR: begin
				if (got) begin
					if (word_data[loader_pkg::SIG_MSB:loader_pkg::SIG_LSB] == loader_pkg::HDR_SIG) begin
						next_hdr_ok = 1'b1;
						next_pending = word_data[3:0];
						next_state = route(word_data[3:0]);
					end else begin
						next_state = loader_pkg::ST_IDLE;
					end
				end
			end
			loader_pkg::ST_SKIP: begin
				// local and identity zones belong to other loaders; walk past them
				if (got && !cont) begin
					if (pending[loader_pkg::ZF_LOCAL]) begin
						next_pending[loader_pkg::ZF_LOCAL] = 1'b0;
					end else begin
						next_pending[loader_pkg::ZF_IDENT] = 1'b0;
					end
					next_state = route(next_pending);
				end
			end
			loader_pkg::ST_FHDR: begin
				if (got) begin
					if (cont) begin
						next_func_ok = word_data[loader_pkg::FN_MSB:loader_pkg::FN_LSB] == loader_pkg::FN_FIRST;
						next_rsvd_seen = rsvd_seen ||
							word_data[loader_pkg::FN_MSB:loader_pkg::FN_LSB] != loader_pkg::FN_FIRST;
						next_state = loader_pkg::ST_CFG;
					end else begin
						next_pending[loader_pkg::ZF_PCI] = 1'b0;
						next_state = route(next_pending);
					end
				end
			end
			loader_pkg::ST_CFG: begin
				if (got) begin
					// words for a reserved function are consumed but not applied
					next_wr_valid = func_ok;
					next_wr_offset = word_data[loader_pkg::OFS_MSB:loader_pkg::OFS_LSB];
					next_wr_data = word_data[loader_pkg::DAT_MSB:loader_pkg::DAT_LSB];
					if (!cont) begin
						next_state = loader_pkg::ST_FHDR;
					end
				end
			end
			loader_pkg::ST_FA1: begin
				if (got) begin
					next_first_word = word_data;
					next_state = loader_pkg::ST_FA2;
				end
			end
			loader_pkg::ST_FA2: begin
				if (got) begin
					next_fa_more = cont;
					next_fa_window = win_code == loader_pkg::WIN_ONE;
					next_fa_write = first_word[loader_pkg::RW_BIT];
					next_fa_offset = first_word[loader_pkg::DAT_MSB:loader_pkg::DAT_LSB];
					next_fa_wdata = word_data[loader_pkg::DAT_MSB:loader_pkg::DAT_LSB];
					if (win_code == loader_pkg::WIN_ZERO || win_code == loader_pkg::WIN_ONE) begin
						next_fa_req = 1'b1;
						next_state = loader_pkg::ST_FACC;
					end else begin
						// reserved window: skip the access, keep walking the zone
						next_rsvd_seen = 1'b1;
						next_state = cont ? loader_pkg::ST_FA1 : loader_pkg::ST_IDLE;
					end
				end
			end
			loader_pkg::ST_FACC: begin
				// returned read byte is dropped
				if (fa_ack) begin
					next_fa_req = 1'b0;
					next_state = fa_more ? loader_pkg::ST_FA1 : loader_pkg::ST_IDLE;
				end
			end
		endcase
		if (state != loader_pkg::ST_IDLE && next_state == loader_pkg::ST_IDLE) begin
			next_pci_retry = 1'b0;
			next_loaded = 1'b1;
			next_word_req = 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			state <= loader_pkg::ST_HDR;
			word_req <= 1'b0;
			word_addr <= '0;
			pending <= 4'h0;
			func_ok <= 1'b0;
			first_word <= 16'h0000;
			fa_more <= 1'b0;
			fa_req <= 1'b0;
			fa_window <= 1'b0;
			fa_write <= 1'b0;
			fa_offset <= 8'h00;
			fa_wdata <= 8'h00;
			wr_valid <= 1'b0;
			wr_offset <= 7'h00;
			wr_data <= 8'h00;
			pci_retry <= 1'b1;
			hdr_ok <= 1'b0;
			rsvd_seen <= 1'b0;
			loaded <= 1'b0;
		end else begin
			state <= next_state;
			word_req <= next_word_req;
			word_addr <= next_word_addr;
			pending <= next_pending;
			func_ok <= next_func_ok;
			first_word <= next_first_word;
			fa_more <= next_fa_more;
			fa_req <= next_fa_req;
			fa_window <= next_fa_window;
			fa_write <= next_fa_write;
			fa_offset <= next_fa_offset;
			fa_wdata <= next_fa_wdata;
			wr_valid <= next_wr_valid;
			wr_offset <= next_wr_offset;
			wr_data <= next_wr_data;
			pci_retry <= next_pci_retry;
			hdr_ok <= next_hdr_ok;
			rsvd_seen <= next_rsvd_seen;
			loaded <= next_loaded;
		end
	end

	// apb slave: one wait state so that pready and prdata come from flops
	always_comb begin
		next_pready = psel && penable && !pready;
		next_pslverr = 1'b0;
		next_prdata = prdata;
		next_reload_req = 1'b0;
		if (next_pready) begin
			next_prdata = 32'h0000_0000;
			unique case (paddr)
				loader_pkg::REG_CTRL: next_prdata = 32'h0000_0000;
				loader_pkg::REG_STATUS: next_prdata = {28'h0000000, loaded, rsvd_seen, hdr_ok,
					state != loader_pkg::ST_IDLE};
				loader_pkg::REG_IDS: next_prdata = {wr.image[loader_pkg::IDX_SUBSYS*loader_pkg::BYTE_W +: 16],
					wr.image[loader_pkg::IDX_DEV*loader_pkg::BYTE_W +: 16]};
				loader_pkg::REG_CLASS: next_prdata = {wr.image[loader_pkg::IDX_INTPIN*loader_pkg::BYTE_W +: 8],
					wr.image[loader_pkg::IDX_CLASS*loader_pkg::BYTE_W +: 24]};
				loader_pkg::REG_PM: next_prdata = {8'h00, wr.image[loader_pkg::IDX_STAT*loader_pkg::BYTE_W +: 8],
					wr.image[loader_pkg::IDX_PM*loader_pkg::BYTE_W +: 16]};
				default: next_pslverr = 1'b1;
			endcase
		end
		if (psel && penable && pready && pwrite && paddr == loader_pkg::REG_CTRL) begin
			next_reload_req = pwdata[loader_pkg::CTRL_RELOAD];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (reset) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
			reload_req <= 1'b0;
		end else begin
			pready <= next_pready;
			pslverr <= next_pslverr;
			prdata <= next_prdata;
			reload_req <= next_reload_req;
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset);

	sequence last_access;
		state == loader_pkg::ST_FACC && fa_ack && !fa_more;
	endsequence
	sequence load_closed;
		state == loader_pkg::ST_IDLE && !pci_retry && loaded;
	endsequence
	sequence pair_fetched;
		$past(state) == loader_pkg::ST_FA2 && $past(got);
	endsequence

	retry_busy_a: assert property (pci_retry == (state != loader_pkg::ST_IDLE))
		else $error("retry does not track the load");
	zone_order_a: assert property (state == loader_pkg::ST_HDR && got &&
		word_data[loader_pkg::SIG_MSB:loader_pkg::SIG_LSB] == loader_pkg::HDR_SIG &&
		word_data[3:0] == 4'h1 |=> state == loader_pkg::ST_FA1)
		else $error("header routed to wrong zone");
	fhdr_open_a: assert property (state == loader_pkg::ST_FHDR && got && cont |=> state == loader_pkg::ST_CFG)
		else $error("function header did not open a function");
	zone_exit_a: assert property (state == loader_pkg::ST_FHDR && got && !cont |=>
		state == ($past(pending[loader_pkg::ZF_FACC]) ? loader_pkg::ST_FA1 : loader_pkg::ST_IDLE))
		else $error("wrong step after the override zone");
	cfg_word_a: assert property (state == loader_pkg::ST_CFG && got && func_ok |=>
		wr_valid && wr_offset == $past(word_data[14:8]) && wr_data == $past(word_data[7:0]))
		else $error("config word not forwarded");
	cfg_last_a: assert property (state == loader_pkg::ST_CFG && got && !cont |=> state == loader_pkg::ST_FHDR)
		else $error("last config word did not close function");
	pair_first_a: assert property ($rose(fa_req) |-> pair_fetched)
		else $error("access started before both words fetched");
	fa_fields_a: assert property (fa_req |-> fa_write == first_word[11] && fa_offset == first_word[7:0] &&
		fa_window == first_word[12] && first_word[14:13] == 2'b00)
		else $error("access fields do not match first word");
	load_end_a: assert property (last_access |=> load_closed)
		else $error("load did not end after last access");
	pci_hold_a: assert property (fa_req |-> pci_retry)
		else $error("function access while pci is open");
endmodule // cfg_loader
`default_nettype wire

// [ee_word_model.sv]
// behavioural configuration memory answering the loader's word requests
`default_nettype none
module ee_word_model (
	input wire logic ref_clk,
	input wire logic reset,
	input wire logic slow,
	input wire logic word_req,
	input wire logic [7:0] word_addr,
	output logic word_ack,
	output logic [15:0] word_data,
	output var int last_addr,
	output var int addr_errs
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] mem [256];
	int wait_cnt;
	initial begin
		word_ack = 1'b0;
		word_data = 16'h0000;
		last_addr = -1;
		addr_errs = 0;
		wait_cnt = 0;
	end
	always @(posedge ref_clk) begin
		if (reset || word_ack) begin
			word_ack <= 1'b0;
			// released data never keeps its last value
			word_data <= ~word_data;
		end else if (word_req) begin
			if (wait_cnt > 0) begin
				wait_cnt <= wait_cnt - 1;
			end else begin
				// a new load restarts at word zero, otherwise words run in order
				if (word_addr != 8'h00 && int'(word_addr) != last_addr + 1) addr_errs <= addr_errs + 1;
				last_addr <= int'(word_addr);
				word_ack <= 1'b1;
				word_data <= mem[word_addr];
				wait_cnt <= slow ? int'($urandom_range(12, 0)) : 0;
			end
		end
	end
endmodule // ee_word_model
`default_nettype wire

// [cfg_loader_bench.sv]
// self-checking bench of the configuration-memory loader
`default_nettype none
`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin n_fail++; \
	$display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp); end end
module cfg_loader_bench;
	timeunit 1ns;
	timeprecision 1ps;
	// default image of the override store
	localparam logic [87:0] IMG0 = 88'h00_01_01_00_00_00_00_00_00_00_01;
	typedef struct {logic win; logic wr; logic [7:0] ofs; logic [7:0] dat; int widx;} fa_t;
	logic ref_clk, reset, psel, penable, pwrite, pready, pslverr, slow;
	logic [7:0] paddr, word_addr, fa_offset, fa_wdata, fa_rdata;
	logic [31:0] pwdata, prdata;
	logic word_req, word_ack, fa_req, fa_window, fa_write, fa_ack, pci_retry;
	logic [15:0] word_data;
	logic [87:0] cfg_image;
	int n_fail, n_compared, last_addr, addr_errs, fa_cnt;
	bit fa_seen, fn_ok, rsv;
	logic [7:0] img [11];
	logic [15:0] rom [$];
	fa_t exp_fa [$];
	fa_t fa_keep [$];
	cfg_loader #(.EE_AW(8)) i_cfg_loader (.ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.word_req(word_req), .word_addr(word_addr), .word_ack(word_ack), .word_data(word_data),
		.fa_req(fa_req), .fa_window(fa_window), .fa_write(fa_write), .fa_offset(fa_offset),
		.fa_wdata(fa_wdata), .fa_ack(fa_ack), .fa_rdata(fa_rdata), .pci_retry(pci_retry),
		.cfg_image(cfg_image));
	ee_word_model i_ee_word_model (.ref_clk(ref_clk), .reset(reset), .slow(slow), .word_req(word_req),
		.word_addr(word_addr), .word_ack(word_ack), .word_data(word_data), .last_addr(last_addr),
		.addr_errs(addr_errs));
	initial begin
		ref_clk = 1'b0;
		forever #2.5 ref_clk = ~ref_clk;
	end
	task automatic test_done();
		if (n_fail == 0 && n_compared > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (40000) @(posedge ref_clk);
		n_fail++;
		test_done();
	end
	function automatic logic [87:0] packed_img();
		logic [87:0] v;
		for (int i = 0; i < 11; i++) v[8*i +: 8] = img[i];
		return v;
	endfunction
	task automatic begin_rom(input logic [15:0] hdr);
		rom.delete();
		exp_fa.delete();
		rsv = 1'b0;
		fn_ok = 1'b0;
		for (int i = 0; i < 11; i++) img[i] = IMG0[8*i +: 8];
		rom.push_back(hdr);
	endtask
	task automatic fhdr(input logic [2:0] fn);
		rom.push_back({13'h1000, fn});
		fn_ok = (fn == 3'h0);
		if (!fn_ok) rsv = 1'b1;
	endtask
	task automatic cfgw(input logic [6:0] ofs, input logic [7:0] dat, input logic more);
		rom.push_back({more, ofs, dat});
		for (int i = 0; i < 11; i++)
			if (fn_ok && loader_pkg::CFG_OFS[i] == ofs) img[i] = (ofs == 7'h06) ? (dat & 8'h10) : dat;
	endtask
	task automatic fa(input logic [2:0] win, input logic wr, input logic [7:0] ofs, input logic [7:0] dat,
		input logic more);
		fa_t e;
		rom.push_back({1'b1, win, wr, 3'h0, ofs});
		rom.push_back({more, 7'h00, dat});
		e = '{win[0], wr, ofs, dat, rom.size() - 1};
		if (win < 3'h2) exp_fa.push_back(e);
		else rsv = 1'b1;
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
		output logic e);
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		// no wait-state count assumed; only the watchdog ends a stuck access
		do begin
			@(posedge ref_clk);
		end while (pready !== 1'b1);
		`CHK(pready, 1'b1)
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic go_reset();
		for (int i = 0; i < rom.size(); i++) i_ee_word_model.mem[i] = rom[i];
		reset <= 1'b1;
		repeat (3) @(posedge ref_clk);
		reset <= 1'b0;
		`CHK(cfg_image, IMG0)
		`CHK(pci_retry, 1'b1)
	endtask
	task automatic load_check(input logic hdr_ok);
		logic [31:0] r;
		logic e;
		for (int n = 0; n < 20 && pci_retry !== 1'b1; n++) @(posedge ref_clk);
		`CHK(pci_retry, 1'b1)
		for (int n = 0; n < 20000 && pci_retry !== 1'b0; n++) @(posedge ref_clk);
		`CHK(pci_retry, 1'b0)
		`CHK(cfg_image, packed_img())
		`CHK(exp_fa.size(), 0)
		`CHK(addr_errs, 0)
		apb(1'b0, 8'h04, 32'($urandom), r, e);
		`CHK(r[3:0], {1'b1, rsv, hdr_ok, 1'b0})
		`CHK(e, 1'b0)
		apb(1'b0, 8'h08, 32'($urandom), r, e);
		`CHK(r, {img[7], img[6], img[1], img[0]})
		apb(1'b0, 8'h0C, 32'($urandom), r, e);
		`CHK(r, {img[8], img[5], img[4], img[3]})
		apb(1'b0, 8'h10, 32'($urandom), r, e);
		`CHK(r, {8'h00, img[2], img[10], img[9]})
		apb(1'b1, 8'h14, 32'($urandom), r, e);
		`CHK(e, 1'b1)
	endtask
	// stands in for the local bus: random latency, moving read data
	initial begin
		fa_ack = 1'b0;
		fa_rdata = 8'h00;
		forever begin
			@(posedge ref_clk);
			fa_rdata <= 8'($urandom);
			if (fa_ack) begin
				fa_ack <= 1'b0;
				fa_seen = 1'b0;
			end else if (fa_req === 1'b1) begin
				if (!fa_seen) begin
					fa_seen = 1'b1;
					fa_cnt = int'($urandom_range(5, 0));
					if (exp_fa.size() == 0) begin
						`CHK(fa_req, 1'b0)
					end else begin
						`CHK(fa_window, exp_fa[0].win)
						`CHK(fa_write, exp_fa[0].wr)
						`CHK(fa_offset, exp_fa[0].ofs)
						if (exp_fa[0].wr) `CHK(fa_wdata, exp_fa[0].dat)
						`CHK(last_addr, exp_fa[0].widx)
						`CHK(pci_retry, 1'b1)
						void'(exp_fa.pop_front());
					end
				end
				if (fa_cnt == 0) fa_ack <= 1'b1;
				else fa_cnt--;
			end
		end
	end
	initial begin
		logic [31:0] r;
		logic e;
		reset = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		slow = 1'b0;
		n_fail = 0;
		n_compared = 0;
		r = $urandom(32'hBDABA3E3);
		// memory latency random for the first image as well
		slow = 1'($urandom);
		// override zone then function accesses, one reserved window among them
		begin_rom(16'h8403);
		fhdr(3'h0);
		for (int i = 0; i < 11; i++) cfgw(loader_pkg::CFG_OFS[i], 8'($urandom), 1'b1);
		cfgw(7'h00, 8'hAB, 1'b1);
		cfgw(7'h2C, 8'hCD, 1'b1);
		cfgw(7'h01, 8'hEF, 1'b1);
		cfgw(7'h06, 8'hFF, 1'b0);
		rom.push_back(16'h0000);
		fa(3'h0, 1'b1, 8'($urandom), 8'($urandom), 1'b1);
		fa(3'h1, 1'b0, 8'hFF, 8'($urandom), 1'b1);
		fa(3'h5, 1'b1, 8'h10, 8'h20, 1'b1);
		fa(3'h1, 1'b1, 8'h00, 8'($urandom), 1'b0);
		fa_keep = exp_fa;
		go_reset();
		load_check(1'b1);
		// same image again through the reload control bit
		exp_fa = fa_keep;
		apb(1'b1, 8'h00, {31'($urandom), 1'b1}, r, e);
		load_check(1'b1);
		// local and identity zones walked past, reserved function ignored, no access zone
		slow = 1'b1;
		begin_rom(16'h840E);
		rom.push_back(16'h8123);
		rom.push_back(16'h0045);
		rom.push_back(16'h0155);
		fhdr(3'h7);
		cfgw(7'h02, 8'h77, 1'b1);
		cfgw(7'h3D, 8'h66, 1'b0);
		fhdr(3'h0);
		cfgw(7'h3D, 8'h04, 1'b0);
		rom.push_back(16'h0000);
		go_reset();
		load_check(1'b1);
		// access zone alone with a slow memory
		begin_rom(16'h8401);
		fa(3'h0, 1'b0, 8'h80, 8'h00, 1'b0);
		go_reset();
		load_check(1'b1);
		// bad signature stops the load at once
		slow = 1'b0;
		begin_rom(16'h1234);
		go_reset();
		load_check(1'b0);
		test_done();
	end
endmodule // cfg_loader_bench
`default_nettype wire
